// >>> hw/szd_top.sv
// zone safe feedback and forced dynamization logic with axi4-lite registers
`timescale 1ns/1ps
module szd_top #(
  parameter int MS_CYCLES = szd_pkg::CYC_PER_MS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [szd_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [szd_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic safe_state_reached,
  input wire logic [szd_pkg::SEL_W-1:0] selection_in,
  output logic [szd_pkg::SEL_W-1:0] selection_out,
  output logic selection_valid,
  input wire logic zone_toggle_i,
  output logic zone_toggle_o,
  input wire logic zone_acknowledge_bus_io_i,
  output logic zone_acknowledge_bus_io_o,
  output logic zone_acknowledge_bus_io_oe_n,
  input wire logic dynamization_io_line_i,
  output logic dynamization_io_line_o,
  output logic dynamization_io_line_oe_n,
  output logic zone_safety_status_output,
  output logic zone_safety_status_output_n,
  output logic diag_ch2_o,
  output logic diag_ch2_oe_n,
  output logic safety_error
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_h;
    logic w_h;
    logic [szd_pkg::ADDR_W-1:0] waddr;
    logic [31:0] wdat;
    logic [3:0] wstb;
    logic [szd_pkg::CTRL_W-1:0] ctrl;
    logic [31:0] intv;
    logic [31:0] pulse;
    logic [31:0] hostcw;
    logic [31:0] ivl_cnt;
    logic [31:0] pls_cnt;
    logic dyn_act;
    logic [szd_pkg::ERR_W-1:0] err;
    logic tog;
    logic tog_prev;
    logic [szd_pkg::TOG_CNT_W-1:0] tog_ms;
    logic [szd_pkg::TOG_CNT_W-1:0] tog_wd;
    logic zone_st;
    logic zone_st_n;
    logic ack_oe_n;
    logic diag;
    logic diag_oe_n;
    logic dyn_o;
    logic dyn_oe_n;
    logic [szd_pkg::SEL_W-1:0] sel;
    logic sel_valid;
    logic safe_err;
  } szd_top_s;

  szd_top_s s, n;
  logic tick;
  logic [szd_pkg::SEL_W+2:0] pin_sync;
  logic tog_in, ack_in, dyn_in;
  logic [szd_pkg::SEL_W-1:0] sel_in;
  logic fb_zone_mst, fb_slave, fieldbus, dyn_mst, pulse_in;

  ////////////////////////////////////////////////////////////////////////
  // register index decode, shared by read and write paths
  function automatic logic [2:0] reg_idx(input logic [szd_pkg::ADDR_W-1:0] a);
    case (a)
      szd_pkg::OFS_CTRL: reg_idx = 3'h0;
      szd_pkg::OFS_INTV: reg_idx = 3'h1;
      szd_pkg::OFS_PULSE: reg_idx = 3'h2;
      szd_pkg::OFS_STAT: reg_idx = 3'h3;
      szd_pkg::OFS_HOSTCW: reg_idx = 3'h4;
      default: reg_idx = 3'h7;
    endcase
  endfunction : reg_idx

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  szd_tick #(.DIV(MS_CYCLES)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );

  // pins come from outside the clock domain
  szd_sync #(.W(szd_pkg::SEL_W + 3)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({selection_in, dynamization_io_line_i, zone_acknowledge_bus_io_i, zone_toggle_i}),
    .q(pin_sync)
  );
  assign tog_in = pin_sync[0];
  assign ack_in = pin_sync[1];
  assign dyn_in = pin_sync[2];
  assign sel_in = pin_sync[szd_pkg::SEL_W+2:3];

  // configuration decode
  assign fb_zone_mst = (s.ctrl[1:0] == szd_pkg::FB_PLC) && s.ctrl[szd_pkg::CB_ZONE_MST];
  assign fb_slave = (s.ctrl[1:0] == szd_pkg::FB_SLAVE);
  assign fieldbus = s.ctrl[szd_pkg::CB_FIELDBUS];
  assign dyn_mst = s.ctrl[szd_pkg::CB_DYN_MST];
  // the host word path serves only a non-master axis; a master ignores pulse_in
  assign pulse_in = s.ctrl[szd_pkg::CB_SRC_HOST] ? s.hostcw[szd_pkg::HB_DYN] : dyn_in;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = s;
    // axi4-lite write: address and data in either order, response after both
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (awvalid && s.awready) begin
      n.aw_h = 1'b1;
      n.waddr = awaddr;
    end
    if (wvalid && s.wready) begin
      n.w_h = 1'b1;
      n.wdat = wdata;
      n.wstb = wstrb;
    end
    if (n.aw_h && n.w_h && !n.bvalid) begin
      n.aw_h = 1'b0;
      n.w_h = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = szd_pkg::RESP_OKAY;
      case (reg_idx(n.waddr))
        3'h0: n.ctrl = szd_pkg::CTRL_W'(merge({24'h00_0000, s.ctrl}, n.wdat, n.wstb));
        3'h1: n.intv = merge(s.intv, n.wdat, n.wstb);
        3'h2: n.pulse = merge(s.pulse, n.wdat, n.wstb);
        3'h3: begin
          if (n.wstb[0]) begin
            n.err = s.err & ~n.wdat[szd_pkg::ERR_W-1:0];
          end
        end
        3'h4: n.hostcw = merge(s.hostcw, n.wdat, n.wstb);
        default: n.bresp = szd_pkg::RESP_SLVERR;
      endcase
    end
    n.awready = !n.aw_h;
    n.wready = !n.w_h;
    // axi4-lite read
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end
    if (arvalid && s.arready) begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = szd_pkg::RESP_OKAY;
      n.rdata = '0;
      case (reg_idx(araddr))
        3'h0: n.rdata[szd_pkg::CTRL_W-1:0] = s.ctrl;
        3'h1: n.rdata = s.intv;
        3'h2: n.rdata = s.pulse;
        3'h3: begin
          n.rdata[szd_pkg::ERR_W-1:0] = s.err;
          n.rdata[szd_pkg::SB_DYN_ACT] = s.dyn_act;
          n.rdata[szd_pkg::SB_ZONE] = s.zone_st;
        end
        3'h4: n.rdata = s.hostcw;
        default: n.rresp = szd_pkg::RESP_SLVERR;
      endcase
    end

    // zone toggle: master drives it, the zone master and slave axes watch it in normal operation
    n.tog_prev = tog_in;
    if (fieldbus || !fb_zone_mst) begin
      n.tog = 1'b0;
      n.tog_ms = '0;
    end else if (tick) begin
      if (s.tog_ms >= szd_pkg::TOG_CNT_W'(szd_pkg::TOG_HALF_MS - 1)) begin
        n.tog_ms = '0;
        n.tog = !s.tog;
      end else begin
        n.tog_ms = s.tog_ms + 1'b1;
      end
    end
    if (fieldbus || safe_state_reached || fb_slave == 1'b0 && !fb_zone_mst ||
        tog_in != s.tog_prev) begin
      n.tog_wd = '0;
    end else if (tick) begin
      if (s.tog_wd >= szd_pkg::TOG_CNT_W'(szd_pkg::TOG_TIMEOUT_MS - 1)) begin
        n.tog_wd = '0;
        n.err[szd_pkg::SB_ERR_TOG] = 1'b1;
      end else begin
        n.tog_wd = s.tog_wd + 1'b1;
      end
    end

    // acknowledge is open drain; released once the axis is safe, so the
    // wired line reads high only when every axis of the zone is safe
    n.ack_oe_n = fieldbus || safe_state_reached;
    n.zone_st = 1'b0;
    if (!fieldbus) begin
      case (s.ctrl[1:0])
        szd_pkg::FB_DOOR: n.zone_st = safe_state_reached;
        szd_pkg::FB_PLC: n.zone_st = safe_state_reached &&
                                     (!s.ctrl[szd_pkg::CB_ZONE_MST] || ack_in);
        default: n.zone_st = 1'b0;
      endcase
    end
    n.zone_st_n = !n.zone_st;
    n.diag = ~|s.err;
    n.diag_oe_n = fieldbus || (fb_slave && s.ctrl[szd_pkg::CB_DIAG_OFF]);

    // forced dynamization
    if (fieldbus) begin
      n.dyn_act = 1'b0;
      n.ivl_cnt = '0;
      n.pls_cnt = '0;
    end else if (dyn_mst) begin
      if (!s.dyn_act) begin
        n.pls_cnt = '0;
        if (tick) begin
          if (s.ivl_cnt + 32'h0000_0001 >= s.intv) begin
            n.ivl_cnt = '0;
            n.dyn_act = 1'b1;
          end else begin
            n.ivl_cnt = s.ivl_cnt + 32'h0000_0001;
          end
        end
      end else if (tick) begin
        if (s.pls_cnt + 32'h0000_0001 >= s.pulse) begin
          n.pls_cnt = '0;
          n.dyn_act = 1'b0;
        end else begin
          n.pls_cnt = s.pls_cnt + 32'h0000_0001;
        end
      end
    end else begin
      n.dyn_act = pulse_in;
      if (pulse_in) begin
        n.ivl_cnt = '0;
        if (tick) begin
          if (s.pls_cnt >= s.pulse) begin
            n.err[szd_pkg::SB_ERR_LONG] = 1'b1;
          end else begin
            n.pls_cnt = s.pls_cnt + 32'h0000_0001;
          end
        end
      end else begin
        n.pls_cnt = '0;
        if (tick) begin
          if (s.ivl_cnt + 32'h0000_0001 >= s.intv) begin
            n.ivl_cnt = '0;
            n.err[szd_pkg::SB_ERR_TMO] = 1'b1;
          end else begin
            n.ivl_cnt = s.ivl_cnt + 32'h0000_0001;
          end
        end
      end
    end
    n.dyn_o = dyn_mst && !fieldbus && n.dyn_act;
    n.dyn_oe_n = !dyn_mst || fieldbus;
    // selection is frozen during a pulse, which lengthens the reaction time
    if (n.dyn_act) begin
      n.sel_valid = 1'b0;
    end else begin
      n.sel = sel_in;
      n.sel_valid = 1'b1;
    end
    n.safe_err = |n.err;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.ctrl <= szd_pkg::CTRL_RST;
      s.intv <= szd_pkg::INTV_RST;
      s.pulse <= szd_pkg::PULSE_RST;
      s.zone_st_n <= 1'b1;
      s.ack_oe_n <= 1'b1;
      s.diag_oe_n <= 1'b1;
      s.dyn_oe_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;
  assign selection_out = s.sel;
  assign selection_valid = s.sel_valid;
  assign zone_toggle_o = s.tog;
  assign zone_acknowledge_bus_io_o = 1'b0 & s.ack_oe_n;
  assign zone_acknowledge_bus_io_oe_n = s.ack_oe_n;
  assign dynamization_io_line_o = s.dyn_o;
  assign dynamization_io_line_oe_n = s.dyn_oe_n;
  assign zone_safety_status_output = s.zone_st;
  assign zone_safety_status_output_n = s.zone_st_n;
  assign diag_ch2_o = s.diag;
  assign diag_ch2_oe_n = s.diag_oe_n;
  assign safety_error = s.safe_err;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // leaving master mode drops the toggle one cycle later, so the older mode counts too
  a_toggle_master_only: assert property ($changed(s.tog) |->
                                         $past(fb_zone_mst) || $past(fb_zone_mst, 2))
    else $error("zone toggle moved outside zone master mode");
  a_ack_release: assert property (!fieldbus && safe_state_reached |=> s.ack_oe_n)
    else $error("acknowledge not released in safe status");
  a_zone_status_safe: assert property (s.zone_st |-> $past(safe_state_reached))
    else $error("zone status raised without safe status");
  a_diag_slave_off: assert property (fb_slave && s.ctrl[szd_pkg::CB_DIAG_OFF] |=> diag_ch2_oe_n)
    else $error("slave diagnostic output still driven");
  a_fieldbus_quiet: assert property (fieldbus |=> !s.dyn_act && s.dyn_oe_n)
    else $error("dynamization active under fieldbus profile");
  a_master_drives: assert property (dyn_mst && !fieldbus |=> !s.dyn_oe_n ##0 s.dyn_o == s.dyn_act)
    else $error("dynamization master not driving its line");
  a_master_pulse_len: assert property (dyn_mst && s.dyn_act |-> s.pls_cnt < s.pulse)
    else $error("master pulse ran past configured duration");
  a_sel_frozen: assert property (s.dyn_act && $past(s.dyn_act) |-> $stable(s.sel) && !s.sel_valid)
    else $error("selection changed during dynamization");
  a_slave_timeout: assert property (!dyn_mst && !fieldbus && !pulse_in && tick &&
                                    s.ivl_cnt + 32'h0000_0001 >= s.intv |=>
                                    s.err[szd_pkg::SB_ERR_TMO] && safety_error)
    else $error("missing pulse not flagged");
  a_slave_long: assert property (!dyn_mst && !fieldbus && pulse_in && tick && s.pls_cnt >= s.pulse
                                 |=> s.err[szd_pkg::SB_ERR_LONG])
    else $error("over-long pulse not flagged");
endmodule : szd_top

// >>> hw/szd_pkg.sv
// constants, register map and types of the zone feedback and dynamization block
package szd_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1_000_000;
  localparam int CYC_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam real DYN_INTERVAL_S = 60.0;
  localparam real DYN_PULSE_S = 0.2;
  localparam int DYN_INTERVAL_MS = $rtoi(DYN_INTERVAL_S * 1000.0);
  localparam int DYN_PULSE_MS = $rtoi(DYN_PULSE_S * 1000.0);
  // zone toggle half period and watchdog, in ms
  localparam int TOG_HALF_MS = 10;
  localparam int TOG_TIMEOUT_MS = 50;
  localparam int TOG_CNT_W = 16;

  ////////////////////////////////////////////////////////////////////////
  // bus and register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INTV = 8'h04;
  localparam logic [7:0] OFS_PULSE = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_HOSTCW = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control register fields
  localparam int CTRL_W = 8;
  localparam int CB_FB_LO = 0;
  localparam int CB_ZONE_MST = 2;
  localparam int CB_DIAG_OFF = 3;
  localparam int CB_DYN_MST = 4;
  localparam int CB_SRC_HOST = 5;
  localparam int CB_FIELDBUS = 6;
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [31:0] INTV_RST = 32'(DYN_INTERVAL_MS);
  localparam logic [31:0] PULSE_RST = 32'(DYN_PULSE_MS);

  // status register fields; error bits are write-one-to-clear
  localparam int SB_ERR_TMO = 0;
  localparam int SB_ERR_LONG = 1;
  localparam int SB_ERR_TOG = 2;
  localparam int SB_DYN_ACT = 4;
  localparam int SB_ZONE = 5;
  localparam int ERR_W = 3;
  localparam int HB_DYN = 0;
  localparam int SEL_W = 2;

  typedef enum logic [1:0] {
    FB_DOOR = 2'b00,
    FB_PLC = 2'b01,
    FB_SLAVE = 2'b10
  } szd_fb_e;
endpackage : szd_pkg

// >>> hw/szd_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module szd_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } szd_sync_s;
  szd_sync_s s, n;

  always_comb begin
    n.meta = d;
    n.q = s.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign q = s.q;
endmodule : szd_sync

// >>> hw/szd_tick.sv
// millisecond tick prescaler
`timescale 1ns/1ps
module szd_tick #(
  parameter int DIV = 100000
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } szd_tick_s;
  szd_tick_s s, n;

  always_comb begin
    n = s;
    n.tick = 1'b0;
    if (s.cnt >= 32'(DIV - 1)) begin
      n.cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = s.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick = s.tick;
endmodule : szd_tick

// >>> bench/szd_zone_peer.sv
// neighbours of the zone: toggle source, wired acknowledge bus, dynamization line
`timescale 1ns/1ps
module szd_zone_peer #(
  parameter int HALF = 40
) (
  input wire logic aclk,
  input wire logic tog_run,
  input wire logic hold_low,
  input wire logic ext_pulse,
  input wire logic dyn_o,
  input wire logic dyn_oe_n,
  input wire logic ack_o,
  input wire logic ack_oe_n,
  output logic tog,
  output logic dyn_line,
  output logic ack_line
);
  int tcnt = 0;
  initial tog = 1'b0;
  ////////////////////////////////////////////////////////////////////////
  // the one other zone master; stops on command to model a broken link
  always @(posedge aclk) begin
    tcnt <= (tcnt == HALF - 1) ? 0 : tcnt + 1;
    if (tog_run && tcnt == HALF - 1) begin
      tog <= ~tog;
    end
  end
  // hold_low stands for any of up to 24 neighbours not yet safe; pulled up
  assign ack_line = (ack_oe_n | ack_o) & ~hold_low;
  // released line follows ext_pulse, so another axis can drive the pulse
  assign dyn_line = !dyn_oe_n ? dyn_o : ext_pulse;
endmodule : szd_zone_peer

// >>> bench/safety_zone_dynamization_tb.sv
// self-checking bench of the zone feedback and dynamization block
`timescale 1ns/1ps
module safety_zone_dynamization_tb;
  localparam int MSC = 4;
  logic aclk;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = '0;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic safe = 1'b0;
  logic [1:0] sel_in = 2'b00;
  logic [1:0] sel_out;
  logic sel_ok;
  logic tog_i;
  logic tog_o;
  logic ack_i;
  logic ack_o;
  logic ack_oe_n;
  logic dyn_i;
  logic dyn_o;
  logic dyn_oe_n;
  logic zst;
  logic zst_n;
  logic diag;
  logic diag_oe_n;
  logic serr;
  logic tog_run = 1'b1;
  logic hold_low = 1'b0;
  logic ext = 1'b0;
  logic [31:0] d;
  int err_total = 0;
  int checked = 0;
  int c;

  szd_top #(.MS_CYCLES(MSC)) i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .safe_state_reached(safe), .selection_in(sel_in),
    .selection_out(sel_out), .selection_valid(sel_ok), .zone_toggle_i(tog_i),
    .zone_toggle_o(tog_o), .zone_acknowledge_bus_io_i(ack_i),
    .zone_acknowledge_bus_io_o(ack_o), .zone_acknowledge_bus_io_oe_n(ack_oe_n),
    .dynamization_io_line_i(dyn_i), .dynamization_io_line_o(dyn_o),
    .dynamization_io_line_oe_n(dyn_oe_n), .zone_safety_status_output(zst),
    .zone_safety_status_output_n(zst_n), .diag_ch2_o(diag), .diag_ch2_oe_n(diag_oe_n),
    .safety_error(serr));
  szd_zone_peer #(.HALF(10 * MSC)) i_peer (.aclk(aclk), .tog_run(tog_run),
    .hold_low(hold_low), .ext_pulse(ext), .dyn_o(dyn_o), .dyn_oe_n(dyn_oe_n),
    .ack_o(ack_o), .ack_oe_n(ack_oe_n), .tog(tog_i), .dyn_line(dyn_i), .ack_line(ack_i));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic ms(input int n);
    repeat (n * MSC) @(posedge aclk);
  endtask : ms
  // bready is raised with the request; legal, and it saves a cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 200);
    bready <= 1'b0;
    chk("bvalid", 32'h1, {31'h0, bvalid});
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 200);
    rready <= 1'b0;
    chk("rvalid", 32'h1, {31'h0, rvalid});
    v = rdata;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : rd
  // clear errors only after a fresh pulse, since a pending error would set again
  task automatic pulse_clr();
    ext <= 1'b1;
    ms(2);
    ext <= 1'b0;
    wr(szd_pkg::OFS_STAT, 32'h0000_0007, szd_pkg::RESP_OKAY);
  endtask : pulse_clr
  task automatic stat_is(input logic [31:0] m, input logic [31:0] ex);
    rd(szd_pkg::OFS_STAT, d, szd_pkg::RESP_OKAY);
    chk("stat", ex, d & m);
  endtask : stat_is
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(szd_pkg::OFS_CTRL, d, szd_pkg::RESP_OKAY);
    chk("ctrl", 32'h0000_0001, d);
    rd(szd_pkg::OFS_INTV, d, szd_pkg::RESP_OKAY);
    chk("intv", 32'h0000_ea60, d);
    rd(szd_pkg::OFS_PULSE, d, szd_pkg::RESP_OKAY);
    chk("pulse", 32'h0000_00c8, d);
    rd(szd_pkg::OFS_HOSTCW, d, szd_pkg::RESP_OKAY);
    chk("hostcw", 32'h0000_0000, d);
    rd(8'h14, d, szd_pkg::RESP_SLVERR);
    wr(8'h14, 32'h0000_00ff, szd_pkg::RESP_SLVERR);
    for (int m = 0; m < 3; m++) begin
      wr(szd_pkg::OFS_CTRL, 32'(m), szd_pkg::RESP_OKAY);
      rd(szd_pkg::OFS_CTRL, d, szd_pkg::RESP_OKAY);
      chk("mode", 32'(m), d);
    end
  endtask : t_regs
  task automatic t_dyn_master();
    wr(szd_pkg::OFS_INTV, 32'h0000_0005, szd_pkg::RESP_OKAY);
    wr(szd_pkg::OFS_PULSE, 32'h0000_0002, szd_pkg::RESP_OKAY);
    wr(szd_pkg::OFS_CTRL, 32'h0000_0031, szd_pkg::RESP_OKAY);
    sel_in <= 2'b01;
    c = 0;
    do begin
      @(posedge aclk);
      c++;
    end while (dyn_i !== 1'b1 && c < 400);
    chk("line_driven", 32'h0, {31'h0, dyn_oe_n});
    repeat (4) @(posedge aclk);
    chk("sel_valid", 32'h0, {31'h0, sel_ok});
    sel_in <= 2'b10;
    c = 4;
    while (dyn_i === 1'b1 && c < 400) begin
      @(posedge aclk);
      c++;
    end
    chk("pulse_len", 32'(2 * MSC), 32'(c));
    repeat (10) @(posedge aclk);
    chk("sel_out", 32'h2, {30'h0, sel_out});
    chk("sel_valid", 32'h1, {31'h0, sel_ok});
    c = 10;
    while (dyn_i !== 1'b1 && c < 400) begin
      @(posedge aclk);
      c++;
    end
    chk("gap_ok", 32'h1, {31'h0, c >= 5 * MSC - 8 && c <= 7 * MSC});
  endtask : t_dyn_master
  task automatic t_slave_line();
    wr(szd_pkg::OFS_CTRL, 32'h0000_0001, szd_pkg::RESP_OKAY);
    wr(szd_pkg::OFS_INTV, 32'h0000_000a, szd_pkg::RESP_OKAY);
    wr(szd_pkg::OFS_PULSE, 32'h0000_0003, szd_pkg::RESP_OKAY);
    pulse_clr();
    repeat (3) begin
      ms(4);
      ext <= 1'b1;
      ms(2);
      ext <= 1'b0;
    end
    stat_is(32'h7, 32'h0);
    ms(12);
    stat_is(32'h7, 32'h1);
    chk("safety_error", 32'h1, {31'h0, serr});
    pulse_clr();
    stat_is(32'h7, 32'h0);
    ext <= 1'b1;
    ms(6);
    ext <= 1'b0;
    stat_is(32'h2, 32'h2);
  endtask : t_slave_line
  task automatic t_slave_host();
    wr(szd_pkg::OFS_CTRL, 32'h0000_0021, szd_pkg::RESP_OKAY);
    pulse_clr();
    repeat (3) begin
      wr(szd_pkg::OFS_HOSTCW, 32'h0000_0001, szd_pkg::RESP_OKAY);
      ms(2);
      wr(szd_pkg::OFS_HOSTCW, 32'h0000_0000, szd_pkg::RESP_OKAY);
      ms(4);
    end
    stat_is(32'h7, 32'h0);
  endtask : t_slave_host
  task automatic t_fieldbus();
    wr(szd_pkg::OFS_CTRL, 32'h0000_0041, szd_pkg::RESP_OKAY);
    pulse_clr();
    ms(15);
    stat_is(32'h7, 32'h0);
  endtask : t_fieldbus
  task automatic t_zone_master();
    wr(szd_pkg::OFS_CTRL, 32'h0000_0005, szd_pkg::RESP_OKAY);
    safe <= 1'b1;
    d = {31'h0, tog_o};
    c = 0;
    do begin
      @(posedge aclk);
      c++;
    end while (tog_o === d[0] && c < 100);
    d = {31'h0, tog_o};
    c = 0;
    do begin
      @(posedge aclk);
      c++;
    end while (tog_o === d[0] && c < 100);
    chk("toggle_half", 32'(10 * MSC), 32'(c));
    ms(1);
    chk("zone_status", 32'h1, {31'h0, zst});
    chk("zone_status_n", 32'h0, {31'h0, zst_n});
    hold_low <= 1'b1;
    repeat (10) @(posedge aclk);
    chk("zone_status", 32'h0, {31'h0, zst});
    chk("zone_status_n", 32'h1, {31'h0, zst_n});
    hold_low <= 1'b0;
  endtask : t_zone_master
  task automatic t_zone_slave();
    wr(szd_pkg::OFS_CTRL, 32'h0000_0002, szd_pkg::RESP_OKAY);
    ms(1);
    chk("diag_oe_n", 32'h0, {31'h0, diag_oe_n});
    wr(szd_pkg::OFS_CTRL, 32'h0000_000a, szd_pkg::RESP_OKAY);
    safe <= 1'b0;
    ms(1);
    chk("diag_oe_n", 32'h1, {31'h0, diag_oe_n});
    chk("ack_oe_n", 32'h0, {31'h0, ack_oe_n});
    chk("ack_o", 32'h0, {31'h0, ack_o});
    wr(szd_pkg::OFS_STAT, 32'h0000_0007, szd_pkg::RESP_OKAY);
    ms(80);
    stat_is(32'h4, 32'h0);
    tog_run <= 1'b0;
    ms(60);
    stat_is(32'h4, 32'h4);
    chk("safety_error", 32'h1, {31'h0, serr});
    chk("diag", 32'h0, {31'h0, diag});
    safe <= 1'b1;
    ms(1);
    chk("ack_oe_n", 32'h1, {31'h0, ack_oe_n});
  endtask : t_zone_slave
  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    #200_000;
    err_total++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_dyn_master();
    t_slave_line();
    t_slave_host();
    t_fieldbus();
    t_zone_master();
    t_zone_slave();
    test_done();
  end
endmodule : safety_zone_dynamization_tb
